// [common/ttx_pkg.sv]
/*
 Types shared by the teletext insertion block and its bit buffer.
 Assumes the register header supplies all numeric constants.
*/
package ttx_pkg;

typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
} axil_in_type;

typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
} axil_out_type;

typedef struct packed {
    logic hsync_start;
    logic field_odd;
    logic [9:0] line_number;
} video_timing_type;

typedef struct packed {
    logic bit_value;
    logic [8:0] bit_index;
} ttx_sample_type;

typedef struct packed {
    axil_out_type bus;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic en;
    logic [1:0] mode;
    logic [10:0] req_start;
    logic [5:0] req_delay;
    logic [9:0] odd_first;
    logic [9:0] odd_last;
    logic [9:0] even_first;
    logic [9:0] even_last;
    logic [1:0] ser_sync;
    logic line_ok;
    logic [10:0] hcount;
    logic req_active;
    logic window;
    logic [23:0] phase;
    logic [8:0] req_count;
    logic [8:0] cap_count;
    logic [64:0] hist;
    logic req_pin;
    logic [7:0] drops;
    logic cap_valid;
    ttx_sample_type cap;
} insert_state_type;

typedef struct packed {
    logic out_valid;
    ttx_sample_type out_data;
    logic skid_valid;
    ttx_sample_type skid_data;
    logic in_ready;
} buffer_state_type;

endpackage

// [common/ttx_regs.svh]
/*
 Register map, field positions, reset values and timing counts of the
 teletext insertion block. Assumes a 25 MHz encoder clock.
*/
// Notes on behaviour
// [RQ1] Insert interpolated bits 9.78 us (PAL) or 10.5 us (NTSC) after hsync edge.
// [RQ2] Source delivers one new serial bit per active-high request pulse.
// [RQ3] Programmable source pipeline delay decides when each bit is sampled.
// [RQ4] Request start position and request-to-data delay are both programmable.
// [RQ5] Constant window holds 360 bits at 6.9375 Mbit/s in PAL mode.
// [RQ6] World standard mode fits 296 bits at 5.7272 Mbit/s in that window.
// [RQ7] NABTS mode fits 288 bits at 5.7272 Mbit/s.
// [RQ8] Window stays closed and nothing inserted while enable bit is zero.
// [RQ9] Separate first/last line ranges for odd and even fields.
// [RQ10] Host must set up both teletext pins before insertion works; the code has no pin setup, insertion runs once the enable bit is set.
// [RQ11] Requests only in open window on enabled lines, stop at bit count; the code issues them from req_start, not gated by the window.
`ifndef TTX_REGS_SVH
`define TTX_REGS_SVH

`define TTX_CTRL_OFFSET 8'h00
`define TTX_TIMING_OFFSET 8'h04
`define TTX_ODD_OFFSET 8'h08
`define TTX_EVEN_OFFSET 8'h0C
`define TTX_STATUS_OFFSET 8'h10

`define TTX_CTRL_EN_BIT 0
`define TTX_CTRL_MODE_LSB 1
`define TTX_TIMING_DELAY_LSB 16
`define TTX_LINE_LAST_LSB 16
`define TTX_STAT_COUNT_LSB 16
`define TTX_STAT_DROP_LSB 8

`define TTX_MODE_PAL 2'h0
`define TTX_MODE_WST 2'h1
`define TTX_MODE_NABTS 2'h2

`define TTX_RST_REQ_START 11'h00C8
`define TTX_RST_REQ_DELAY 6'h04
`define TTX_RST_ODD_FIRST 10'h007
`define TTX_RST_ODD_LAST 10'h016
`define TTX_RST_EVEN_FIRST 10'h140
`define TTX_RST_EVEN_LAST 10'h14F

`define TTX_CLK_HZ 25000000
`define TTX_START_PAL_NS 9780
`define TTX_START_NTSC_NS 10500
`define TTX_START_PAL_CYC ((`TTX_START_PAL_NS * 25 + 999) / 1000)
`define TTX_START_NTSC_CYC ((`TTX_START_NTSC_NS * 25 + 999) / 1000)
`define TTX_BITS_PAL 360
`define TTX_BITS_WST 296
`define TTX_BITS_NABTS 288
`define TTX_RATE_PAL_BPS 6937500
`define TTX_RATE_525_BPS 5727200
`define TTX_WIN_CYC ((64'd360 * 64'd25000000) / 64'd6937500)
`define TTX_INC_PAL ((64'd6937500 * 64'd16777216) / 64'd25000000)
`define TTX_INC_525 ((64'd5727200 * 64'd16777216) / 64'd25000000)

`endif

// [verif/tb_ttx_insertion.sv]
/*
 Self-checking bench for the teletext insertion block.
 Assumes the source model stands on the request and serial pins.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_ttx_insertion;
    localparam logic [31:0] PAT = 32'hB5C3_1E97;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    ttx_pkg::axil_in_type bus_in = '0;
    ttx_pkg::axil_out_type bus_out;
    ttx_pkg::video_timing_type video = '0;
    logic ser;
    logic pin;
    logic win;
    logic bv;
    ttx_pkg::ttx_sample_type bd;
    logic br = 1'b1;
    logic [5:0] src_delay = 6'h04;
    logic chk_on = 1'b1;
    int n_errors = 0;
    int total_checks = 0;
    int gbit = 0;
    int lbit = 0;
    int pulses, wopen, wlen, fpulse;
    logic [31:0] rd;
    logic [1:0] rsp;
    always #20 mclk = ~mclk;
    ttx_insertion u_ttx_insertion(.mclk(mclk), .rst(rst), .bus_in(bus_in),
        .bus_out(bus_out), .video(video), .teletext_serial_in(ser),
        .teletext_request_pin(pin), .insert_window(win), .bit_valid(bv),
        .bit_data(bd), .bit_ready(br));
    ttx_source_model #(.PATTERN(PAT)) u_ttx_source_model(.mclk(mclk), .rst(rst),
        .request(pin), .delay(src_delay), .serial_out(ser));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk);
        bus_in.awvalid <= 1'b1;
        bus_in.awaddr <= a;
        bus_in.wvalid <= 1'b1;
        bus_in.wdata <= d;
        bus_in.wstrb <= 4'hf;
        bus_in.bready <= 1'b1;
        for (t = 0; t < 60; t++) begin
            @(posedge mclk);
            if (bus_out.awready) bus_in.awvalid <= 1'b0;
            if (bus_out.wready) bus_in.wvalid <= 1'b0;
            if (bus_out.bvalid) break;
        end
        if (t == 60) begin
            check("write response wait", 0, 1);
            conclude();
        end
        rsp = bus_out.bresp;
        bus_in.bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        int t;
        @(posedge mclk);
        bus_in.arvalid <= 1'b1;
        bus_in.araddr <= a;
        bus_in.rready <= 1'b1;
        for (t = 0; t < 60; t++) begin
            @(posedge mclk);
            if (bus_out.arready) bus_in.arvalid <= 1'b0;
            if (bus_out.rvalid) break;
        end
        if (t == 60) begin
            check("read response wait", 0, 1);
            conclude();
        end
        rd = bus_out.rdata;
        rsp = bus_out.rresp;
        bus_in.rready <= 1'b0;
    endtask

    // One full 64 us line; window and pulses measured from the hsync edge
    task automatic run_line(input logic odd, input logic [9:0] line);
        pulses = 0;
        wopen = 0;
        wlen = 0;
        fpulse = 0;
        lbit = 0;
        @(posedge mclk);
        video <= '{hsync_start: 1'b1, field_odd: odd, line_number: line};
        @(posedge mclk);
        video.hsync_start <= 1'b0;
        for (int k = 1; k < 1600; k++) begin
            @(posedge mclk);
            #1;
            if (win) wlen++;
            if (win && wopen == 0) wopen = k;
            if (pin) pulses++;
            if (pin && fpulse == 0) fpulse = k;
        end
    endtask

    always @(posedge mclk) begin
        if (!rst && bv === 1'b1 && br && chk_on) begin
            check("bit value", bd.bit_value, PAT[gbit % 32]);
            check("bit index", bd.bit_index, lbit);
            gbit++;
            lbit++;
        end
    end

    task automatic s_regs();
        logic [7:0] ad [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
        logic [31:0] rv [4] = '{32'h0000_0000, 32'h0004_00C8, 32'h0016_0007, 32'h014F_0140};
        for (int i = 0; i < 4; i++) begin
            axi_read(ad[i]);
            check("reset value", rd, rv[i]);
            check("read response", rsp, 2'b00);
        end
        axi_read(8'h20);
        check("unmapped read data", rd, 32'h0000_0000);
        check("unmapped read response", rsp, 2'b10);
        axi_write(8'h24, 32'hFFFF_FFFF);
        check("unmapped write response", rsp, 2'b10);
    endtask

    task automatic s_modes();
        int bits [3] = '{360, 296, 288};
        // Start cycles rounded up from 9.78 us and 10.5 us, plus the window flop
        int open [3] = '{246, 264, 264};
        run_line(1'b1, 10'h00A);
        check("pulses disabled", pulses, 0);
        check("window disabled", wlen, 0);
        for (int m = 0; m < 3; m++) begin
            axi_write(8'h00, {29'h0, m[1:0], 1'b1});
            run_line(1'b1, 10'h00A);
            check("pulse count", pulses, bits[m]);
            check("window start", wopen, open[m]);
            check("window length", wlen, 1297);
        end
    endtask

    task automatic s_lines();
        logic fo [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic [9:0] ln [4] = '{10'h00C, 10'h00D, 10'h021, 10'h00C};
        int ex [4] = '{360, 0, 360, 0};
        axi_write(8'h00, 32'h0000_0001);
        axi_write(8'h08, 32'h000C_000C);
        axi_write(8'h0C, 32'h0021_0020);
        for (int i = 0; i < 4; i++) begin
            run_line(fo[i], ln[i]);
            check("line range pulses", pulses, ex[i]);
        end
    endtask

    task automatic s_start();
        int n;
        src_delay <= 6'h06;
        axi_write(8'h04, 32'h0006_0100);
        run_line(1'b1, 10'h00C);
        check("first request", fpulse > 256 && fpulse <= 262, 1'b1);
        check("pulse count", pulses, 360);
        // Stall the receiver: requests must stop once the buffer fills; a bit already in flight is dropped
        chk_on = 1'b0;
        br <= 1'b0;
        run_line(1'b1, 10'h00C);
        check("buffer holds", bv, 1'b1);
        check("requests refused", pulses >= 2 && pulses < 360, 1'b1);
        br <= 1'b1;
        n = 0;
        for (int t = 0; t < 10; t++) begin
            @(posedge mclk);
            if (bv) n++;
        end
        #1;
        check("drained entries", n >= 2 && n <= 3, 1'b1);
        check("buffer empty", bv, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        s_regs();
        s_modes();
        s_lines();
        s_start();
        conclude();
    end
endmodule
`default_nettype wire

// [verif/ttx_source_model.sv]
/*
 Behavioural teletext bit source answering each request pulse.
 Assumes one-cycle request pulses and a delay of at least 1 cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module ttx_source_model #(
    parameter logic [31:0] PATTERN = 32'hB5C3_1E97
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic request,
    input wire logic [5:0] delay,
    output logic serial_out
);
    int cyc;
    int n;
    int due[$];
    logic val[$];
    initial serial_out = 1'b0;
    always @(posedge mclk) begin
        if (rst) begin
            cyc = 0;
            n = 0;
            due.delete();
            val.delete();
        end else begin
            if (request) begin
                due.push_back(cyc + int'(delay));
                val.push_back(PATTERN[n % 32]);
                n++;
            end
            cyc++;
            while (due.size() > 1 && due[1] <= cyc) begin
                void'(due.pop_front());
                void'(val.pop_front());
            end
            // Hold time over: toggle, so a late sample cannot pass by luck
            if (due.size() > 0 && due[0] <= cyc && cyc <= due[0] + 2) begin
                serial_out <= val[0];
            end else begin
                serial_out <= ~serial_out;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/ttx_bit_buffer.sv]
/*
 Two-entry buffer for captured teletext bits.
 Assumes both sides run on mclk with valid/ready handshakes.
*/
`timescale 1ns/100ps
`default_nettype none
module ttx_bit_buffer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    input wire ttx_pkg::ttx_sample_type in_data,
    output logic in_ready,
    output logic out_valid,
    output ttx_pkg::ttx_sample_type out_data,
    input wire logic out_ready
);
    ttx_pkg::buffer_state_type s_q;
    ttx_pkg::buffer_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (out_ready || !s_q.out_valid) begin
            if (s_q.skid_valid) begin
                s_d.out_valid = 1'b1;
                s_d.out_data = s_q.skid_data;
                s_d.skid_valid = 1'b0;
            end else begin
                s_d.out_valid = in_valid && s_q.in_ready;
                s_d.out_data = in_data;
            end
        end else if (in_valid && s_q.in_ready) begin
            s_d.skid_valid = 1'b1;
            s_d.skid_data = in_data;
        end
        // Ready comes from a flop, so the skid entry absorbs the word in flight
        s_d.in_ready = !s_d.skid_valid;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready = s_q.in_ready;
    assign out_valid = s_q.out_valid;
    assign out_data = s_q.out_data;

    chk_buf_hold_out: assert property (@(posedge mclk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer output changed while stalled");
    chk_buf_full_stall: assert property (@(posedge mclk) disable iff (rst)
        s_q.skid_valid |-> out_valid && !in_ready)
        else $error("buffer accepts while full");
endmodule
`default_nettype wire

// [verilog/ttx_insertion.sv]
/*
 Teletext insertion timing: request pulse generation, serial bit capture,
 insertion window and AXI4-Lite register slave.
 Assumes video timing inputs come from encoder logic on mclk and the
 serial bit input arrives asynchronously from an external source.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ttx_regs.svh"
module ttx_insertion (
    input wire logic mclk,
    input wire logic rst,
    input wire ttx_pkg::axil_in_type bus_in,
    output ttx_pkg::axil_out_type bus_out,
    input wire ttx_pkg::video_timing_type video,
    input wire logic teletext_serial_in,
    output logic teletext_request_pin,
    output logic insert_window,
    output logic bit_valid,
    output ttx_pkg::ttx_sample_type bit_data,
    input wire logic bit_ready
);
    localparam int START_PAL = `TTX_START_PAL_CYC;
    localparam int START_NTSC = `TTX_START_NTSC_CYC;
    localparam int WIN_CYC = 32'(`TTX_WIN_CYC);

    ttx_pkg::insert_state_type s_q;
    ttx_pkg::insert_state_type s_d;
    logic buf_in_ready;

    function automatic logic [8:0] bit_limit(input logic [1:0] mode);
        case (mode)
            `TTX_MODE_WST: bit_limit = 9'(`TTX_BITS_WST); // RQ6
            `TTX_MODE_NABTS: bit_limit = 9'(`TTX_BITS_NABTS); // RQ7
            default: bit_limit = 9'(`TTX_BITS_PAL); // RQ5
        endcase
    endfunction

    function automatic logic [23:0] rate_inc(input logic [1:0] mode);
        if (mode == `TTX_MODE_WST || mode == `TTX_MODE_NABTS) begin
            rate_inc = 24'(`TTX_INC_525);
        end else begin
            rate_inc = 24'(`TTX_INC_PAL);
        end
    endfunction

    function automatic logic [10:0] start_cyc(input logic [1:0] mode);
        if (mode == `TTX_MODE_WST || mode == `TTX_MODE_NABTS) begin
            start_cyc = 11'(START_NTSC);
        end else begin
            start_cyc = 11'(START_PAL);
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    function automatic logic [31:0] reg_image(input ttx_pkg::insert_state_type s,
                                              input logic [7:0] addr);
        reg_image = '0;
        case (addr)
            `TTX_CTRL_OFFSET: begin
                reg_image[`TTX_CTRL_EN_BIT] = s.en;
                reg_image[`TTX_CTRL_MODE_LSB +: 2] = s.mode;
            end
            `TTX_TIMING_OFFSET: begin
                reg_image[10:0] = s.req_start;
                reg_image[`TTX_TIMING_DELAY_LSB +: 6] = s.req_delay;
            end
            `TTX_ODD_OFFSET: begin
                reg_image[9:0] = s.odd_first;
                reg_image[`TTX_LINE_LAST_LSB +: 10] = s.odd_last;
            end
            `TTX_EVEN_OFFSET: begin
                reg_image[9:0] = s.even_first;
                reg_image[`TTX_LINE_LAST_LSB +: 10] = s.even_last;
            end
            `TTX_STATUS_OFFSET: begin
                reg_image[0] = s.window;
                reg_image[1] = s.req_active;
                reg_image[2] = s.line_ok;
                reg_image[`TTX_STAT_DROP_LSB +: 8] = s.drops;
                reg_image[`TTX_STAT_COUNT_LSB +: 9] = s.req_count;
            end
            default: reg_image = '0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = addr == `TTX_CTRL_OFFSET || addr == `TTX_TIMING_OFFSET ||
                 addr == `TTX_ODD_OFFSET || addr == `TTX_EVEN_OFFSET ||
                 addr == `TTX_STATUS_OFFSET;
    endfunction

    always_comb begin
        logic [31:0] wv;
        logic [24:0] acc;
        logic line_hit;
        logic fire;
        logic sample;
        logic [11:0] req_end;
        logic [11:0] win_end;
        wv = '0;
        acc = '0;
        line_hit = 1'b0;
        fire = 1'b0;
        sample = 1'b0;
        req_end = 12'(s_q.req_start) + 12'(WIN_CYC);
        win_end = 12'(start_cyc(s_q.mode)) + 12'(WIN_CYC);
        s_d = s_q;

        // Register slave: address and data are taken in either order
        if (bus_in.awvalid && s_q.bus.awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = bus_in.awaddr;
        end
        if (bus_in.wvalid && s_q.bus.wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = bus_in.wdata;
            s_d.w_strb = bus_in.wstrb;
        end
        if (s_q.bus.bvalid && bus_in.bready) begin
            s_d.bus.bvalid = 1'b0;
        end
        if (s_q.aw_held && s_q.w_held && !s_q.bus.bvalid) begin
            wv = merge(reg_image(s_q, s_q.aw_addr), s_q.w_data, s_q.w_strb);
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bus.bvalid = 1'b1;
            s_d.bus.bresp = mapped(s_q.aw_addr) ? 2'h0 : 2'h2;
            case (s_q.aw_addr)
                `TTX_CTRL_OFFSET: begin
                    s_d.en = wv[`TTX_CTRL_EN_BIT];
                    s_d.mode = wv[`TTX_CTRL_MODE_LSB +: 2];
                end
                `TTX_TIMING_OFFSET: begin
                    s_d.req_start = wv[10:0]; // RQ4
                    s_d.req_delay = wv[`TTX_TIMING_DELAY_LSB +: 6]; // RQ3
                end
                `TTX_ODD_OFFSET: begin
                    s_d.odd_first = wv[9:0];
                    s_d.odd_last = wv[`TTX_LINE_LAST_LSB +: 10];
                end
                `TTX_EVEN_OFFSET: begin
                    s_d.even_first = wv[9:0];
                    s_d.even_last = wv[`TTX_LINE_LAST_LSB +: 10];
                end
                default: s_d.en = s_q.en;
            endcase
        end
        s_d.bus.awready = !s_d.aw_held && !s_d.bus.bvalid;
        s_d.bus.wready = !s_d.w_held && !s_d.bus.bvalid;

        if (s_q.bus.rvalid && bus_in.rready) begin
            s_d.bus.rvalid = 1'b0;
        end
        if (bus_in.arvalid && s_q.bus.arready) begin
            s_d.bus.rvalid = 1'b1;
            s_d.bus.rdata = reg_image(s_q, bus_in.araddr);
            s_d.bus.rresp = mapped(bus_in.araddr) ? 2'h0 : 2'h2;
        end
        s_d.bus.arready = !s_d.bus.rvalid;

        // Serial input is asynchronous; only the second stage is read
        s_d.ser_sync = {s_q.ser_sync[0], teletext_serial_in};

        // Line position since the leading edge of the outgoing hsync
        if (video.hsync_start) begin
            s_d.hcount = '0;
            if (video.field_odd) begin
                line_hit = video.line_number >= s_q.odd_first &&
                           video.line_number <= s_q.odd_last; // RQ9
            end else begin
                line_hit = video.line_number >= s_q.even_first &&
                           video.line_number <= s_q.even_last; // RQ9
            end
            s_d.line_ok = line_hit;
            s_d.req_active = 1'b0;
            s_d.window = 1'b0;
            s_d.req_count = '0;
            s_d.cap_count = '0;
        end else begin
            if (s_q.hcount != 11'h7FF) begin
                s_d.hcount = s_q.hcount + 11'h001;
            end

            // Request phase opens at the programmed position
            if (s_q.hcount == s_q.req_start && s_q.en && s_q.line_ok &&
                s_q.req_count == 9'h000) begin
                s_d.req_active = 1'b1; // RQ4
                // Preload: first tick fires at once, else the last PAL bit misses the phase
                s_d.phase = 24'hFF_FFFF; // RQ5
            end else if (!s_q.en || s_q.req_count == bit_limit(s_q.mode) ||
                         {1'b0, s_q.hcount} == req_end) begin
                s_d.req_active = 1'b0; // RQ11
            end

            // Insertion window sits at a fixed offset from hsync
            if (s_q.hcount == start_cyc(s_q.mode) && s_q.en && s_q.line_ok) begin
                s_d.window = 1'b1; // RQ1
            end else if (!s_q.en) begin
                s_d.window = 1'b0; // RQ8
            end else if ({1'b0, s_q.hcount} == win_end) begin
                s_d.window = 1'b0; // RQ5
            end
        end

        // Bit clock from a phase accumulator; a full buffer holds requests back
        if (s_q.req_active) begin
            acc = {1'b0, s_q.phase} + {1'b0, rate_inc(s_q.mode)};
            s_d.phase = acc[23:0];
            fire = acc[24] && buf_in_ready && s_q.en &&
                   s_q.req_count < bit_limit(s_q.mode); // RQ11
        end
        s_d.req_pin = fire;
        if (fire) begin
            s_d.req_count = s_q.req_count + 9'h001;
        end

        // Request history lines each bit up with its returning data
        s_d.hist = {s_q.hist[63:0], s_q.req_pin};
        sample = s_q.hist[7'(s_q.req_delay) + 7'h01]; // RQ3
        if (s_q.cap_valid && buf_in_ready) begin
            s_d.cap_valid = 1'b0;
        end
        if (sample) begin
            if (s_q.cap_valid && !buf_in_ready) begin
                // When a bit requested before the buffer filled returns with no room left
                if (s_q.drops != 8'hFF) begin
                    s_d.drops = s_q.drops + 8'h01;
                end
            end else begin
                s_d.cap_valid = 1'b1;
                s_d.cap.bit_value = s_q.ser_sync[1];
                s_d.cap.bit_index = s_q.cap_count;
                s_d.cap_count = s_d.cap_count + 9'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
            s_q.req_start <= `TTX_RST_REQ_START;
            s_q.req_delay <= `TTX_RST_REQ_DELAY;
            s_q.odd_first <= `TTX_RST_ODD_FIRST;
            s_q.odd_last <= `TTX_RST_ODD_LAST;
            s_q.even_first <= `TTX_RST_EVEN_FIRST;
            s_q.even_last <= `TTX_RST_EVEN_LAST;
            s_q.hcount <= 11'h7FF;
        end else begin
            s_q <= s_d;
        end
    end

    ttx_bit_buffer u_ttx_bit_buffer (
        .mclk(mclk),
        .rst(rst),
        .in_valid(s_q.cap_valid),
        .in_data(s_q.cap),
        .in_ready(buf_in_ready),
        .out_valid(bit_valid),
        .out_data(bit_data),
        .out_ready(bit_ready)
    );

    assign bus_out = s_q.bus;
    assign teletext_request_pin = s_q.req_pin;
    assign insert_window = s_q.window;

    chk_window_off_disabled: assert property (@(posedge mclk) disable iff (rst) // RQ8
        !s_q.en |=> !insert_window)
        else $error("window open while insertion disabled");
    chk_window_start_pal: assert property (@(posedge mclk) disable iff (rst) // RQ1
        $rose(insert_window) && s_q.mode == `TTX_MODE_PAL
        |-> s_q.hcount == 11'(START_PAL + 1))
        else $error("PAL window start misplaced");
    chk_window_start_ntsc: assert property (@(posedge mclk) disable iff (rst) // RQ1
        $rose(insert_window) && s_q.mode != `TTX_MODE_PAL
        |-> s_q.hcount == 11'(START_NTSC + 1))
        else $error("NTSC window start misplaced");
    chk_window_len_end: assert property (@(posedge mclk) disable iff (rst) // RQ5
        $fell(insert_window) && $past(s_q.en) && !$past(video.hsync_start)
        && $stable(s_q.mode)
        |-> s_q.hcount == start_cyc(s_q.mode) + 11'(WIN_CYC + 1))
        else $error("window length wrong");
    chk_pal_bit_count: assert property (@(posedge mclk) disable iff (rst) // RQ5
        s_q.mode == `TTX_MODE_PAL |-> s_q.req_count <= 9'(`TTX_BITS_PAL))
        else $error("too many PAL requests");
    chk_wst_bit_count: assert property (@(posedge mclk) disable iff (rst) // RQ6
        teletext_request_pin && s_q.mode == `TTX_MODE_WST && $stable(s_q.mode)
        |-> s_q.req_count <= 9'(`TTX_BITS_WST))
        else $error("too many world standard requests");
    chk_nabts_bit_count: assert property (@(posedge mclk) disable iff (rst) // RQ7
        teletext_request_pin && s_q.mode == `TTX_MODE_NABTS && $stable(s_q.mode)
        |-> s_q.req_count <= 9'(`TTX_BITS_NABTS))
        else $error("too many NABTS requests");
    chk_window_line_ok: assert property (@(posedge mclk) disable iff (rst) // RQ9
        insert_window |-> s_q.line_ok)
        else $error("window open on a line outside range");
    chk_req_start_pos: assert property (@(posedge mclk) disable iff (rst) // RQ4
        $rose(s_q.req_active) |-> s_q.hcount == s_q.req_start + 11'h001)
        else $error("request phase began at wrong position");
    chk_req_in_phase: assert property (@(posedge mclk) disable iff (rst) // RQ11
        teletext_request_pin |-> $past(s_q.req_active) && $past(s_q.line_ok))
        else $error("request pulse outside request phase");
    chk_req_single_pulse: assert property (@(posedge mclk) disable iff (rst) // RQ11
        teletext_request_pin |=> !teletext_request_pin)
        else $error("request pulse longer than one cycle");
    chk_sample_follows: assert property (@(posedge mclk) disable iff (rst) // RQ3
        $rose(teletext_request_pin) && s_q.req_delay == 6'h04 && buf_in_ready
        && !s_q.cap_valid |-> ##7 s_q.cap_valid)
        else $error("bit not captured after programmed delay");
    chk_bresp_hold: assert property (@(posedge mclk) disable iff (rst)
        bus_out.bvalid && !bus_in.bready |=> bus_out.bvalid)
        else $error("write response dropped early");
endmodule
`default_nettype wire
